//--- rtl/csr_pkg.sv
// Purpose: shared constants and state types for calibration save/restore and reset sequencing
// Assumes: one clock domain, clk_sys at 25 MHz
// Notes: counts are in clk_sys cycles
package csr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 9;
    localparam int SCRATCH_WORDS_DEF = 512;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int RST_SYNC_STAGES = 2;
    localparam int RST_ASSERT_DELAY = 3;
    localparam int UCLK_HOLD_CYCLES = 4;
    localparam int RESTORE_EN_WINDOW = 50;
    localparam int GATE_CAL_CYCLES = 40;
    localparam int CNT_W = ADDR_W + 1;

    typedef enum logic [3:0] {
        CAL_RESET,
        CAL_BOOT_WAIT,
        CAL_FULL,
        CAL_WAIT_RESTORE,
        CAL_LOAD,
        CAL_GATE,
        CAL_DONE,
        CAL_SAVE_DRAIN,
        CAL_SAVED
    } csr_cal_state_type;

    typedef enum logic [3:0] {
        HST_RESET,
        HST_IDLE,
        HST_RESTORE_WR,
        HST_WR_WAIT,
        HST_RESTORE_HOLD,
        HST_SAVE_REQ,
        HST_SAVE_RD,
        HST_RD_WAIT,
        HST_FINISH
    } csr_host_state_type;

    function automatic logic [CNT_W-1:0] csr_inc(input logic [CNT_W-1:0] v);
        csr_inc = v + {{(CNT_W-1){1'b0}}, 1'b1};
    endfunction
endpackage

//--- rtl/csr_link_if.sv
// Purpose: link between the controller end and the user fabric end
// Assumes: both ends on clk_sys
// Notes: scratch port carries one command at a time
`timescale 1ns/100ps
`default_nettype none
interface csr_link_if;
    logic user_side_reset;
    logic calib_done;
    logic save_req;
    logic save_ack;
    logic restore_en;
    logic restore_complete;
    logic scratch_select;
    logic scratch_rd_en;
    logic scratch_wr_en;
    logic [csr_pkg::ADDR_W-1:0] scratch_addr;
    logic [csr_pkg::DATA_W-1:0] scratch_wr_data;
    logic [csr_pkg::DATA_W-1:0] scratch_rd_data;
    logic scratch_rdy;

    modport dev (
        output user_side_reset, calib_done, save_ack, scratch_rd_data, scratch_rdy,
        input save_req, restore_en, restore_complete, scratch_select, scratch_rd_en,
        input scratch_wr_en, scratch_addr, scratch_wr_data
    );
    modport usr (
        input user_side_reset, calib_done, save_ack, scratch_rd_data, scratch_rdy,
        output save_req, restore_en, restore_complete, scratch_select, scratch_rd_en,
        output scratch_wr_en, scratch_addr, scratch_wr_data
    );
endinterface
`default_nettype wire

//--- rtl/csr_dev.sv
// Purpose: controller end: reset sync, calibration sequencer, scratch RAM port, save handshake
// Assumes: reset_n is the system reset pin; dram_busy comes from the controller on clk_sys
// Notes: calibration engine is a stand-in that fills the scratch RAM and counts stages
//
// Operation
// (R1) user raises restore-enable within 50 cycles
// (R2) user writes saved scratch contents back
// (R3) restore-complete after every location rewritten, held
// (R4) restore-enable at boot means restore boot
// (R5) restore-complete loads scratch RAM into PHY
// (R6) restore skips all but strobe gate training
// (R7) after restore calibration, normal traffic accepted
// (R8) system reset clears the whole design; the scratch RAM and FIFO arrays have no reset and keep their contents
// (R9) calibration logic apart from fabric clock; here it shares clk_sys with the fabric
// (R10) system reset synchronised into user-side reset
// (R11) user-side reset asserted and released synchronously
// (R12) user-side reset rises cycles after reset
// (R13) user clock runs a few cycles more
// (R14) design in reset while user-side reset high
// (R15) calibration-done low while user-side reset high
// (R16) calibration-done only after calibration finishes
// (R17) save request only after done, traffic stopped
// (R18) save-acknowledge after pending commands, held
// (R19) one-cycle enable issues one scratch command
// (R20) ready pulse acknowledges each command
`timescale 1ns/100ps
`default_nettype none
module csr_dev #(
    parameter int SCRATCH_WORDS = csr_pkg::SCRATCH_WORDS_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    csr_link_if.dev link,
    input wire logic dram_busy,
    output logic phy_load_valid,
    output logic [csr_pkg::ADDR_W-1:0] phy_load_addr,
    output logic [csr_pkg::DATA_W-1:0] phy_load_data,
    output logic traffic_ok,
    output logic restore_boot,
    output logic user_clk_run
);
    import csr_pkg::*;

    localparam int IDX_W = $clog2(SCRATCH_WORDS);

    if (SCRATCH_WORDS < 2 || SCRATCH_WORDS > (1 << ADDR_W) || (1 << IDX_W) != SCRATCH_WORDS) begin : g_bad_words
        $error("SCRATCH_WORDS must be a power of two within the address range");
    end

    localparam logic [CNT_W-1:0] LAST_WORD = CNT_W'(SCRATCH_WORDS - 1);
    localparam logic [CNT_W-1:0] WINDOW_END = CNT_W'(RESTORE_EN_WINDOW);
    localparam logic [CNT_W-1:0] GATE_END = CNT_W'(GATE_CAL_CYCLES - 1);
    localparam logic [2:0] HOLD_END = 3'(UCLK_HOLD_CYCLES);

    // reset sequencing: no async reset here, so assertion stays synchronous
    logic [RST_SYNC_STAGES-1:0] rst_sync_q;
    logic [RST_ASSERT_DELAY-1:0] rst_dly_q, rst_dly_d;
    logic [2:0] hold_q, hold_d;
    logic clk_run_q, clk_run_d;
    logic srst;

    always_ff @(posedge clk_sys) begin
        rst_sync_q <= {rst_sync_q[RST_SYNC_STAGES-2:0], ~reset_n}; // [R10]
    end

    always_comb begin
        rst_dly_d = {rst_dly_q[RST_ASSERT_DELAY-2:0], rst_sync_q[RST_SYNC_STAGES-1]}; // [R11] [R12]
        hold_d = hold_q;
        clk_run_d = clk_run_q;
        if (!srst) begin
            hold_d = 3'h0;
            clk_run_d = 1'b1;
        end else if (hold_q != HOLD_END) begin
            hold_d = hold_q + 3'h1; // [R13]
        end else begin
            clk_run_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        rst_dly_q <= rst_dly_d;
        hold_q <= hold_d;
        clk_run_q <= clk_run_d;
    end

    assign srst = rst_dly_q[RST_ASSERT_DELAY-1];
    assign link.user_side_reset = srst;
    assign user_clk_run = clk_run_q;

    // calibration sequencer; a separate clock would need a crossing, kept on clk_sys here [R9]
    csr_cal_state_type st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic restore_q, restore_d;
    logic done_q, done_d;
    logic ack_q, ack_d;
    logic traffic_q, traffic_d;
    logic load_v_q, load_v_d;
    logic [ADDR_W-1:0] load_a_q, load_a_d;
    logic cal_wr;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        restore_d = restore_q;
        done_d = done_q;
        ack_d = ack_q;
        load_v_d = 1'b0;
        load_a_d = load_a_q;
        cal_wr = 1'b0;
        case (st_q)
            CAL_RESET: begin
                cnt_d = '0;
                st_d = CAL_BOOT_WAIT;
            end
            CAL_BOOT_WAIT: begin
                if (link.restore_en) begin // [R4] [R1]
                    restore_d = 1'b1;
                    st_d = CAL_WAIT_RESTORE;
                end else if (cnt_q == WINDOW_END) begin
                    cnt_d = '0;
                    st_d = CAL_FULL;
                end else begin
                    cnt_d = csr_inc(cnt_q);
                end
            end
            CAL_FULL: begin
                // full run leaves one result per scratch word
                cal_wr = 1'b1;
                cnt_d = csr_inc(cnt_q);
                if (cnt_q == LAST_WORD) begin
                    cnt_d = '0;
                    st_d = CAL_GATE;
                end
            end
            CAL_WAIT_RESTORE: begin
                if (link.restore_complete) begin // [R3] [R2]
                    cnt_d = '0;
                    st_d = CAL_LOAD;
                end
            end
            CAL_LOAD: begin
                load_v_d = 1'b1; // [R5]
                load_a_d = cnt_q[ADDR_W-1:0];
                cnt_d = csr_inc(cnt_q);
                if (cnt_q == LAST_WORD) begin
                    cnt_d = '0;
                    st_d = CAL_GATE; // [R6]
                end
            end
            CAL_GATE: begin
                cnt_d = csr_inc(cnt_q);
                if (cnt_q == GATE_END) begin
                    done_d = 1'b1; // [R16]
                    st_d = CAL_DONE;
                end
            end
            CAL_DONE: begin
                if (link.save_req) begin // [R17]
                    st_d = CAL_SAVE_DRAIN;
                end
            end
            CAL_SAVE_DRAIN: begin
                if (!dram_busy) begin
                    ack_d = 1'b1; // [R18]
                    st_d = CAL_SAVED;
                end
            end
            CAL_SAVED: begin
                ack_d = 1'b1;
            end
            default: begin
                st_d = CAL_RESET;
            end
        endcase
        traffic_d = (st_d == CAL_DONE); // [R7]
        if (srst) begin // [R14] [R15]
            st_d = CAL_RESET;
            cnt_d = '0;
            restore_d = 1'b0;
            done_d = 1'b0;
            ack_d = 1'b0;
            traffic_d = 1'b0;
            load_v_d = 1'b0;
            load_a_d = '0;
            cal_wr = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin // [R8]
            st_q <= CAL_RESET;
            cnt_q <= '0;
            restore_q <= 1'b0;
            done_q <= 1'b0;
            ack_q <= 1'b0;
            traffic_q <= 1'b0;
            load_v_q <= 1'b0;
            load_a_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            restore_q <= restore_d;
            done_q <= done_d;
            ack_q <= ack_d;
            traffic_q <= traffic_d;
            load_v_q <= load_v_d;
            load_a_q <= load_a_d;
        end
    end

    // scratch port: one command per enable pulse, answered next cycle
    logic rdy_q, rdy_d;
    logic port_rd, port_wr;
    logic [IDX_W-1:0] port_idx;

    always_comb begin
        port_rd = link.scratch_select && link.scratch_rd_en; // [R19]
        port_wr = link.scratch_select && link.scratch_wr_en;
        port_idx = link.scratch_addr[IDX_W-1:0];
        rdy_d = (port_rd || port_wr) && !srst; // [R20]
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= rdy_d;
        end
    end

    // array has no reset; user writes win over the stand-in calibration fill
    logic [DATA_W-1:0] scratch_mem [SCRATCH_WORDS];
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] load_data_q;

    always_ff @(posedge clk_sys) begin
        if (port_wr) begin
            scratch_mem[port_idx] <= link.scratch_wr_data; // [R2]
        end else if (cal_wr) begin
            scratch_mem[cnt_q[IDX_W-1:0]] <= cnt_q[DATA_W-1:0] ^ 9'h0a5;
        end
        if (port_rd) begin
            rd_data_q <= scratch_mem[port_idx];
        end
        load_data_q <= scratch_mem[cnt_q[IDX_W-1:0]];
    end

    assign link.scratch_rdy = rdy_q;
    assign link.scratch_rd_data = rd_data_q;
    assign link.calib_done = done_q;
    assign link.save_ack = ack_q;
    assign phy_load_valid = load_v_q;
    assign phy_load_addr = load_a_q;
    assign phy_load_data = load_data_q;
    assign traffic_ok = traffic_q;
    assign restore_boot = restore_q;
endmodule
`default_nettype wire

//--- rtl/csr_host.sv
// Purpose: user fabric end: saves scratch RAM out through a FIFO and restores it on a restore boot
// Assumes: restore_boot_req is a pin; other user inputs are on clk_sys
// Notes: one scratch command outstanding at a time
`timescale 1ns/100ps
`default_nettype none
module csr_fifo #(
    parameter int WIDTH = csr_pkg::DATA_W,
    parameter int DEPTH = csr_pkg::FIFO_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        in_ready = (cnt_q != (PW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        out_data = mem[rp_q];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_d = push ? wp_q + PW'(1) : wp_q;
        rp_d = pop ? rp_q + PW'(1) : rp_q;
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end
endmodule

module csr_host #(
    parameter int SCRATCH_WORDS = csr_pkg::SCRATCH_WORDS_DEF,
    parameter int FIFO_DEPTH = csr_pkg::FIFO_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    csr_link_if.usr link,
    input wire logic restore_boot_req,
    input wire logic save_start,
    input wire logic ld_valid,
    input wire logic [csr_pkg::DATA_W-1:0] ld_data,
    output logic ld_ready,
    output logic st_valid,
    input wire logic st_ready,
    output logic [csr_pkg::DATA_W-1:0] st_data,
    output logic save_done,
    output logic restore_done
);
    import csr_pkg::*;

    if (SCRATCH_WORDS < 2 || SCRATCH_WORDS > (1 << ADDR_W)) begin : g_bad_words
        $error("SCRATCH_WORDS out of range");
    end

    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(SCRATCH_WORDS - 1);

    logic [1:0] boot_sync_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            boot_sync_q <= 2'h0;
        end else begin
            boot_sync_q <= {boot_sync_q[0], restore_boot_req};
        end
    end

    logic fifo_in_ready;
    logic fifo_push;

    csr_host_state_type st_q, st_d;
    logic ren_q, ren_d, rcmp_q, rcmp_d, sreq_q, sreq_d;
    logic sel_q, sel_d, rd_q, rd_d, wr_q, wr_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdat_q, wdat_d;
    logic ldr_q, ldr_d, sdone_q, sdone_d, rdone_q, rdone_d;

    always_comb begin
        st_d = st_q;
        ren_d = ren_q;
        rcmp_d = rcmp_q;
        sreq_d = sreq_q;
        sel_d = sel_q;
        rd_d = 1'b0; // [R19]
        wr_d = 1'b0;
        addr_d = addr_q;
        wdat_d = wdat_q;
        sdone_d = sdone_q;
        rdone_d = rdone_q;
        fifo_push = 1'b0;
        case (st_q)
            HST_RESET: begin
                if (boot_sync_q[1]) begin
                    ren_d = 1'b1; // [R1]
                    addr_d = '0;
                    st_d = HST_RESTORE_WR;
                end else begin
                    st_d = HST_IDLE;
                end
            end
            HST_IDLE: begin
                if (link.calib_done && save_start) begin
                    sreq_d = 1'b1; // [R17]
                    st_d = HST_SAVE_REQ;
                end
            end
            HST_RESTORE_WR: begin
                if (ld_valid && ldr_q) begin
                    sel_d = 1'b1;
                    wr_d = 1'b1; // [R2]
                    wdat_d = ld_data;
                    st_d = HST_WR_WAIT;
                end
            end
            HST_WR_WAIT: begin
                if (link.scratch_rdy) begin // [R20]
                    if (addr_q == LAST_ADDR) begin
                        sel_d = 1'b0;
                        rcmp_d = 1'b1; // [R3]
                        st_d = HST_RESTORE_HOLD;
                    end else begin
                        addr_d = addr_q + ADDR_W'(1);
                        st_d = HST_RESTORE_WR;
                    end
                end
            end
            HST_RESTORE_HOLD: begin
                if (link.calib_done) begin
                    ren_d = 1'b0;
                    rcmp_d = 1'b0;
                    rdone_d = 1'b1;
                    st_d = HST_IDLE;
                end
            end
            HST_SAVE_REQ: begin
                if (link.save_ack) begin
                    sel_d = 1'b1;
                    addr_d = '0;
                    st_d = HST_SAVE_RD;
                end
            end
            HST_SAVE_RD: begin
                // issue only with room, so the answer always fits
                if (fifo_in_ready) begin
                    rd_d = 1'b1;
                    st_d = HST_RD_WAIT;
                end
            end
            HST_RD_WAIT: begin
                if (link.scratch_rdy) begin // [R20]
                    fifo_push = 1'b1;
                    if (addr_q == LAST_ADDR) begin
                        sel_d = 1'b0;
                        sdone_d = 1'b1;
                        st_d = HST_FINISH;
                    end else begin
                        addr_d = addr_q + ADDR_W'(1);
                        st_d = HST_SAVE_RD;
                    end
                end
            end
            HST_FINISH: begin
                st_d = HST_FINISH;
            end
            default: begin
                st_d = HST_RESET;
            end
        endcase
        ldr_d = (st_d == HST_RESTORE_WR) && !wr_d;
        if (link.user_side_reset) begin // [R14]
            st_d = HST_RESET;
            ren_d = 1'b0;
            rcmp_d = 1'b0;
            sreq_d = 1'b0;
            sel_d = 1'b0;
            rd_d = 1'b0;
            wr_d = 1'b0;
            addr_d = '0;
            ldr_d = 1'b0;
            sdone_d = 1'b0;
            rdone_d = 1'b0;
            fifo_push = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= HST_RESET;
            ren_q <= 1'b0;
            rcmp_q <= 1'b0;
            sreq_q <= 1'b0;
            sel_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= '0;
            wdat_q <= '0;
            ldr_q <= 1'b0;
            sdone_q <= 1'b0;
            rdone_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ren_q <= ren_d;
            rcmp_q <= rcmp_d;
            sreq_q <= sreq_d;
            sel_q <= sel_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            ldr_q <= ldr_d;
            sdone_q <= sdone_d;
            rdone_q <= rdone_d;
        end
    end

    csr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) csr_fifo_inst (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(link.scratch_rd_data),
        .out_valid(st_valid),
        .out_ready(st_ready),
        .out_data(st_data)
    );

    assign link.restore_en = ren_q;
    assign link.restore_complete = rcmp_q;
    assign link.save_req = sreq_q;
    assign link.scratch_select = sel_q;
    assign link.scratch_rd_en = rd_q;
    assign link.scratch_wr_en = wr_q;
    assign link.scratch_addr = addr_q;
    assign link.scratch_wr_data = wdat_q;
    assign ld_ready = ldr_q;
    assign save_done = sdone_q;
    assign restore_done = rdone_q;
endmodule
`default_nettype wire

//--- test/csr_assertions.sv
// Purpose: concurrent checks on the link between controller end and fabric end
// Assumes: one clock, reset_n async active low
// Notes: reset chain rise is hidden by the disable, only its release is checked
`timescale 1ns/100ps
`default_nettype none
module csr_assertions (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic user_side_reset,
    input wire logic calib_done,
    input wire logic save_req,
    input wire logic save_ack,
    input wire logic restore_en,
    input wire logic restore_complete,
    input wire logic scratch_select,
    input wire logic scratch_rd_en,
    input wire logic scratch_wr_en,
    input wire logic scratch_rdy
);
    logic cmd;
    assign cmd = scratch_select && (scratch_rd_en || scratch_wr_en);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    property p_done_low; user_side_reset |-> !calib_done; endproperty
    a_done_low: assert property (p_done_low) else $error("done high in reset");
    property p_rdy_ans; cmd && !user_side_reset |=> scratch_rdy; endproperty
    a_rdy_ans: assert property (p_rdy_ans) else $error("no ready after command");
    property p_rdy_cause; scratch_rdy |-> $past(cmd); endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("ready without command");
    property p_ack_held; save_ack |=> save_ack; endproperty
    a_ack_held: assert property (p_ack_held) else $error("save ack dropped");
    property p_ack_req; $rose(save_ack) |-> calib_done && $past(save_req, 2); endproperty
    a_ack_req: assert property (p_ack_req) else $error("save ack without request");
    property p_done_held; calib_done |=> calib_done; endproperty
    a_done_held: assert property (p_done_held) else $error("done dropped");
    property p_release; $rose(reset_n) |-> user_side_reset [*3] ##[1:4] !user_side_reset; endproperty
    a_release: assert property (p_release) else $error("user reset release timing");
    property p_wait; restore_en && !restore_complete |-> !calib_done; endproperty
    a_wait: assert property (p_wait) else $error("done before restore complete");
    property p_quiet; user_side_reset |-> !scratch_rdy && !save_ack && !save_req; endproperty
    a_quiet: assert property (p_quiet) else $error("activity in reset");
    property p_late; $rose(calib_done) |-> !$past(user_side_reset, 8); endproperty
    a_late: assert property (p_late) else $error("done too soon after reset");
    c_restore: cover property ($rose(calib_done) && restore_en);
    c_save: cover property ($rose(save_ack));
    c_write: cover property (scratch_wr_en && scratch_select);
endmodule
`default_nettype wire

//--- test/calib_save_restore_reset_tb_top.sv
// Purpose: full boot, save through stalled stream, then restore boot
// Assumes: scratch RAM shrunk to 16 words
// Notes: expected words queued by the driver, checked by a monitor
`timescale 1ns/100ps
`default_nettype none
module calib_save_restore_reset_tb_top;
    import csr_pkg::*;
    localparam int NW = 16;
    logic clk_sys, reset_n, dram_busy, restore_boot_req, save_start, ld_valid, st_ready;
    logic phy_load_valid, traffic_ok, restore_boot, user_clk_run, ld_ready, st_valid;
    logic save_done, restore_done;
    logic [DATA_W-1:0] ld_data, st_data, phy_load_data;
    logic [ADDR_W-1:0] phy_load_addr;
    logic [24:0] ql[$];
    logic [DATA_W-1:0] qs[$];
    int mismatches, n_compared, i;
    csr_link_if lnk();
    csr_dev #(.SCRATCH_WORDS(NW)) csr_dev_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link(lnk),
        .dram_busy(dram_busy), .phy_load_valid(phy_load_valid), .phy_load_addr(phy_load_addr),
        .phy_load_data(phy_load_data), .traffic_ok(traffic_ok), .restore_boot(restore_boot),
        .user_clk_run(user_clk_run));
    csr_host #(.SCRATCH_WORDS(NW), .FIFO_DEPTH(8)) csr_host_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .link(lnk), .restore_boot_req(restore_boot_req), .save_start(save_start), .ld_valid(ld_valid),
        .ld_data(ld_data), .ld_ready(ld_ready), .st_valid(st_valid), .st_ready(st_ready),
        .st_data(st_data), .save_done(save_done), .restore_done(restore_done));
    csr_assertions csr_assertions_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .user_side_reset(lnk.user_side_reset), .calib_done(lnk.calib_done), .save_req(lnk.save_req),
        .save_ack(lnk.save_ack), .restore_en(lnk.restore_en), .restore_complete(lnk.restore_complete),
        .scratch_select(lnk.scratch_select), .scratch_rd_en(lnk.scratch_rd_en),
        .scratch_wr_en(lnk.scratch_wr_en), .scratch_rdy(lnk.scratch_rdy));

    task cmp_word(input logic [24:0] exp, input logic [24:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask

    task cmp_flag(input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // bounded so a lost calibration ends in a mismatch, not a hang
    task wait_done;
        for (int k = 0; k < 3000 && lnk.calib_done !== 1'b1; k++) begin
            @(negedge clk_sys);
        end
    endtask

    // hold word until the edge that sees ready, change only at the next fall
    task send_ld;
        ld_valid = 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (ld_ready === 1'b1) break;
        end
        @(negedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test;
    end

    always @(posedge clk_sys) begin
        if (st_valid === 1'b1 && st_ready === 1'b1) begin
            cmp_word({16'h0, qs.pop_front()}, {16'h0, st_data});
        end
        if (phy_load_valid === 1'b1) begin
            cmp_word(ql.pop_front(), {phy_load_addr, phy_load_data});
        end
    end

    initial begin
        reset_n = 1'b0;
        dram_busy = 1'b0;
        restore_boot_req = 1'b0;
        save_start = 1'b0;
        ld_valid = 1'b0;
        ld_data = 9'h000;
        st_ready = 1'b0;
        mismatches = 0;
        n_compared = 0;
        i = $urandom(32'h382c);
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
        wait_done;
        cmp_flag(1'b1, lnk.calib_done);
        cmp_flag(1'b0, restore_boot);
        cmp_flag(1'b1, traffic_ok);
        $display("test full_boot done");
        for (i = 0; i < NW; i++) begin
            qs.push_back(DATA_W'(i) ^ 9'h0a5);
        end
        save_start = 1'b1;
        dram_busy = 1'b1;
        repeat (6) @(negedge clk_sys);
        cmp_flag(1'b0, lnk.save_ack);
        cmp_flag(1'b0, traffic_ok);
        dram_busy = 1'b0;
        save_start = 1'b0;
        // far side stalls: fifo fills and reads must halt
        repeat (40) @(negedge clk_sys);
        cmp_flag(1'b1, st_valid);
        cmp_flag(1'b0, save_done);
        for (i = 0; i < 400 && save_done !== 1'b1; i++) begin
            st_ready = 1'($urandom);
            @(negedge clk_sys);
        end
        st_ready = 1'b1;
        repeat (12) @(negedge clk_sys);
        cmp_flag(1'b1, lnk.save_ack);
        cmp_flag(1'b1, save_done);
        cmp_flag(1'b0, st_valid);
        $display("test save_stream done");
        restore_boot_req = 1'b1;
        reset_n = 1'b0;
        @(negedge clk_sys);
        cmp_flag(1'b0, lnk.user_side_reset);
        repeat (6) @(negedge clk_sys);
        cmp_flag(1'b1, lnk.user_side_reset);
        cmp_flag(1'b1, user_clk_run);
        repeat (7) @(negedge clk_sys);
        cmp_flag(1'b1, lnk.user_side_reset);
        cmp_flag(1'b0, lnk.calib_done);
        cmp_flag(1'b0, lnk.save_ack);
        cmp_flag(1'b0, user_clk_run);
        reset_n = 1'b1;
        for (i = 0; i < NW; i++) begin
            ld_data = DATA_W'($urandom);
            ql.push_back({ADDR_W'(i), ld_data});
            send_ld;
        end
        ld_valid = 1'b0;
        wait_done;
        cmp_flag(1'b1, lnk.calib_done);
        cmp_flag(1'b1, restore_boot);
        cmp_flag(1'b1, traffic_ok);
        repeat (4) @(negedge clk_sys);
        cmp_flag(1'b1, restore_done);
        cmp_flag(1'b1, ql.size() == 0 && qs.size() == 0);
        $display("test restore_boot done");
        stop_test;
    end
endmodule
`default_nettype wire
